// [logic/charger_ctrl_pkg.sv]
package charger_ctrl_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0]  CTRL7_ADDR = 8'h36;
	localparam logic [7:0]  CTRL6_ADDR = 8'h37;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int C6_GATE_OV  = 7;
	localparam int C6_SLEW_EN  = 6;
	localparam int C6_RUV_DIS  = 5;
	localparam int C6_LCH_CLR  = 4;
	localparam int C6_LCH_DIS  = 3;
	localparam int C7_IDLE_SEL = 7;
	localparam int C7_THR_BIT  = 1;
	localparam int C7_ABS_DIS  = 0;

	// ----------------------------------------------------------------
	// reset values and encodings
	// ----------------------------------------------------------------
	localparam logic [2:0]  UV_CODE_OFF  = 3'h0;
	localparam logic [2:0]  UV_CODE_4V8  = 3'h3;
	localparam logic [15:0] CTRL7_RESET  = 16'h0000;
	localparam logic [15:0] CTRL6_RESET  = 16'h0040;
	localparam logic [15:0] CTRL7_MASK   = 16'h0083;
	localparam logic [15:0] CTRL6_MASK   = 16'h00ef;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_MHZ       = 100;
	localparam int SLEW_TICK_NS  = 1000;
	localparam int SLEW_TICK_CYC = (SLEW_TICK_NS * CLK_MHZ + 999) / 1000;
	localparam int SLEW_TICKS    = 16;
	localparam int SLEW_CYC      = SLEW_TICK_CYC * SLEW_TICKS;
	localparam int IDLE_1MS_US   = 1000;
	localparam int IDLE_5MS_US   = 5000;
	localparam int IDLE_40MS_US  = 40000;
	localparam int IDLE_80MS_US  = 80000;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [7:0]  addr;
		logic [15:0] wdata;
	} reg_req_s;

	typedef struct packed {
		logic [15:0] c7;
		logic [15:0] c6;
		logic        latch;
		logic [11:0] ref_now;
		logic [10:0] slew_cnt;
		logic [15:0] rdata;
		logic        strap_done;
	} ctrl_state_s;

endpackage

// [logic/charger_protection_control_regs.sv]
//
// Function
// - overvoltage-gate bit set turns battery switch gate off during system overvoltage.
// - slew enable bit, default set, gates ramp limiting of target references.
// - reference moves one step per sixteen one-microsecond ticks when limiting.
// - reverse undervoltage protection active while its bit is zero.
// - writing one to clear bit erases latched comparator value.
// - with latch enabled, clear bit position reads latched comparator data.
// - comparator latch active when disable bit zero, bypassed when one.
// - three-bit code selects undervoltage threshold, zero disables detection.
// - threshold default disabled on strap high or first battery, else 4.8 V.
// - idle exit timer picked by bank three bit and bank seven bit 7.
// - absolute overvoltage protection enabled while bank seven bit 0 is zero.
// - selection bit routes reverse power good or comparator to shared pin.
`timescale 1ns/1ns
`default_nettype none
module charger_protection_control_regs
	import charger_ctrl_pkg::*;
#(
	parameter int REF_W = 12
) (
	input  wire logic             sys_clk,           // 100 MHz clock
	input  wire logic             resetn,            // async reset, low active
	input  wire reg_req_s         req,               // decoded register access
	output logic [15:0]           rdata,             // read data, registered
	input  wire logic             strap_high,        // config strap tied to supply
	input  wire logic             first_battery,     // first battery insertion seen
	input  wire logic             system_rail_overvoltage, // system rail overvoltage
	output logic                  battery_switch_gate_off, // force gate off
	input  wire logic [REF_W-1:0] ref_target,        // requested reference code
	output logic [REF_W-1:0]      ref_out,           // slewed reference code
	output logic                  reverse_uv_enable, // reverse undervoltage protection on
	input  wire logic             comparator_raw,    // comparator after debounce
	output logic                  comparator_output, // latched or live comparator
	input  wire logic             pin_select_cmp,    // bank five routing bit
	input  wire logic             reverse_power_good,// reverse power good
	output logic                  shared_pin,        // shared output pin level
	output logic [2:0]            uv_threshold_code, // undervoltage threshold code
	output logic                  uv_detect_enable,  // undervoltage detection on
	input  wire logic             bank_three_bit8,   // idle timer select high bit
	output logic [16:0]           idle_exit_us,      // idle exit timer in us
	output logic                  abs_ov_enable      // absolute overvoltage protection on
);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [16:0] idle_us(input logic hi, input logic lo);
		case ({hi, lo})
			2'b00: idle_us = 17'(IDLE_40MS_US);
			2'b01: idle_us = 17'(IDLE_5MS_US);
			2'b10: idle_us = 17'(IDLE_80MS_US);
			default: idle_us = 17'(IDLE_1MS_US);
		endcase
	endfunction

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	// everything the bank remembers sits in one struct: both register
	// images, the comparator latch, the slewed reference, the slew tick
	// counter, the read answer and the strap-load flag. one comb block
	// builds the next copy, one flop block stores it, so no field can
	// pick up a second driver by accident.
	// the clear bit of bank six is never stored: it is an action, and
	// its read position is owned by the latch readback.
	ctrl_state_s s_q;
	ctrl_state_s s_d;
	logic        wr6;
	logic        wr7;

	// write decode; strobes are level-sampled on every rising edge, so a
	// host holding wr for two cycles writes twice, which is harmless here
	// except for the clear bit, which clears the latch twice
	assign wr6 = req.wr && (req.addr == CTRL6_ADDR);
	assign wr7 = req.wr && (req.addr == CTRL7_ADDR);

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	// reference is kept 12 bits wide in the state; wider REF_W is truncated
	// order inside this block matters: the strap load comes first so a
	// host write in the same cycle wins, and the comparator set comes
	// after the clear so an event is never lost to a racing clear.
	// the slew counter runs free, so the first step after a target
	// change lands anywhere within one full period; the limit is a
	// maximum rate, not a fixed delay.
	always_comb begin
		s_d = s_q;
		// the strap is sampled once after reset release, never under reset
		// strap default load
		if (!s_q.strap_done) begin
			s_d.strap_done = 1'b1;
			s_d.c6[2:0] = (strap_high || first_battery) ? UV_CODE_OFF : UV_CODE_4V8;
		end
		if (wr6) begin
			s_d.c6 = req.wdata & CTRL6_MASK;
			s_d.c6[C6_LCH_CLR] = 1'b0;
		end
		if (wr7) begin
			s_d.c7 = req.wdata & CTRL7_MASK;
		end
		// set wins over a clear in the same cycle
		// latch clear
		if (wr6 && req.wdata[C6_LCH_CLR]) begin
			s_d.latch = 1'b0;
		end
		if (comparator_raw) begin
			s_d.latch = 1'b1;
		end
		if (s_q.slew_cnt == 11'(SLEW_CYC - 1)) begin
			s_d.slew_cnt = '0;
		end else begin
			s_d.slew_cnt = s_q.slew_cnt + 11'd1;
		end
		if (!s_q.c6[C6_SLEW_EN]) begin
			s_d.ref_now = 12'(ref_target);
		end else if (s_q.slew_cnt == 11'(SLEW_CYC - 1)) begin
			if (s_q.ref_now < 12'(ref_target)) begin
				s_d.ref_now = s_q.ref_now + 12'd1;
			end else if (s_q.ref_now > 12'(ref_target)) begin
				s_d.ref_now = s_q.ref_now - 12'd1;
			end
		end
		s_d.rdata = '0;
		if (req.rd && req.addr == CTRL6_ADDR) begin
			s_d.rdata = s_q.c6;
			s_d.rdata[C6_LCH_CLR] = s_q.c6[C6_LCH_DIS] ? 1'b0 : s_q.latch;
		end else if (req.rd && req.addr == CTRL7_ADDR) begin
			s_d.rdata = s_q.c7;
		end
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	// reset loads constants only; the strap is taken one edge later so
	// its level never has to be valid while reset is asserted
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '{c7: CTRL7_RESET, c6: CTRL6_RESET, latch: 1'b0, ref_now: '0,
			         slew_cnt: '0, rdata: '0, strap_done: 1'b0};
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	// protection enables are plain decodes of the register images; the
	// gate-off output is combinational on purpose so an overvoltage
	// reaches the gate driver without a clock of delay
	assign rdata = s_q.rdata;
	assign ref_out = REF_W'(s_q.ref_now);
	assign battery_switch_gate_off = s_q.c6[C6_GATE_OV] && system_rail_overvoltage;
	assign reverse_uv_enable = !s_q.c6[C6_RUV_DIS];
	assign comparator_output = s_q.c6[C6_LCH_DIS] ? comparator_raw : s_q.latch;
	assign shared_pin = pin_select_cmp ? comparator_output : reverse_power_good;
	assign uv_threshold_code = s_q.c6[2:0];
	assign uv_detect_enable = (s_q.c6[2:0] != UV_CODE_OFF);
	assign idle_exit_us = idle_us(bank_three_bit8, s_q.c7[C7_IDLE_SEL]);
	assign abs_ov_enable = !s_q.c7[C7_ABS_DIS];

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	// all checks run on the one clock and sleep while reset is held;
	// they look at the state struct as well as the outputs so that a
	// broken output decode and a broken next-state path are told apart
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	// ----------------------------------------------------------------
	// protection enables
	// ----------------------------------------------------------------
	chk_gate_off: assert property ((s_q.c6[C6_GATE_OV] && system_rail_overvoltage) |-> battery_switch_gate_off)
		else $error("gate not off during overvoltage");
	chk_gate_idle: assert property (!s_q.c6[C6_GATE_OV] |-> !battery_switch_gate_off)
		else $error("gate forced off with action disabled");
	chk_ruv: assert property (reverse_uv_enable == !s_q.c6[C6_RUV_DIS])
		else $error("reverse protection wrong");
	chk_abs: assert property (abs_ov_enable != s_q.c7[C7_ABS_DIS])
		else $error("abs overvoltage wrong");

	// ----------------------------------------------------------------
	// reference slew
	// ----------------------------------------------------------------
	chk_slew_off: assert property (!s_q.c6[C6_SLEW_EN] |=> s_q.ref_now == $past(12'(ref_target)))
		else $error("reference not direct with slew off");
	chk_slew_step: assert property ((s_q.c6[C6_SLEW_EN] && s_q.slew_cnt != 11'(SLEW_CYC - 1))
		|=> s_q.ref_now == $past(s_q.ref_now))
		else $error("reference moved between slew ticks");
	chk_slew_up: assert property ((s_q.c6[C6_SLEW_EN] && s_q.slew_cnt == 11'(SLEW_CYC - 1)
		&& s_q.ref_now < 12'(ref_target)) |=> s_q.ref_now == $past(s_q.ref_now) + 12'd1)
		else $error("reference did not step up on tick");
	chk_slew_down: assert property ((s_q.c6[C6_SLEW_EN] && s_q.slew_cnt == 11'(SLEW_CYC - 1)
		&& s_q.ref_now > 12'(ref_target)) |=> s_q.ref_now == $past(s_q.ref_now) - 12'd1)
		else $error("reference did not step down on tick");
	chk_slew_cnt: assert property (s_q.slew_cnt <= 11'(SLEW_CYC - 1))
		else $error("slew counter out of range");

	// ----------------------------------------------------------------
	// comparator latch
	// ----------------------------------------------------------------
	chk_latch_clr: assert property ((wr6 && req.wdata[C6_LCH_CLR] && !comparator_raw) |=> !s_q.latch)
		else $error("latch not cleared");
	chk_clr_bit: assert property (!s_q.c6[C6_LCH_CLR])
		else $error("clear bit stored");
	chk_latch_rd: assert property ((req.rd && req.addr == CTRL6_ADDR && !s_q.c6[C6_LCH_DIS])
		|=> rdata[C6_LCH_CLR] == $past(s_q.latch))
		else $error("latch readback wrong");
	// a write that bypasses the latch in the same cycle may legally drop it
	chk_latch_hold: assert property ((comparator_raw && !s_q.c6[C6_LCH_DIS]
		&& !(wr6 && req.wdata[C6_LCH_DIS])) |=> comparator_output)
		else $error("latch lost comparator event");
	chk_bypass: assert property (s_q.c6[C6_LCH_DIS] |-> comparator_output == comparator_raw)
		else $error("bypass not live");

	// ----------------------------------------------------------------
	// fields, defaults and bus
	// ----------------------------------------------------------------
	chk_uv_off: assert property (uv_detect_enable == (uv_threshold_code != 3'h0))
		else $error("undervoltage enable wrong");
	chk_strap: assert property ((!s_q.strap_done && !wr6)
		|=> s_q.c6[2:0] == ($past(strap_high || first_battery) ? UV_CODE_OFF : UV_CODE_4V8))
		else $error("strap default wrong");
	chk_idle: assert property ((bank_three_bit8 && s_q.c7[C7_IDLE_SEL]) |-> idle_exit_us == 17'd1000)
		else $error("idle timer wrong");
	chk_idle_def: assert property ((!bank_three_bit8 && !s_q.c7[C7_IDLE_SEL]) |-> idle_exit_us == 17'd40000)
		else $error("default idle timer wrong");
	chk_unused: assert property ((req.rd && req.addr == CTRL7_ADDR) |=> rdata[6:2] == 5'h0 && rdata[15:8] == 8'h0)
		else $error("unused bits nonzero");
	chk_img_unused: assert property ((s_q.c6 & ~CTRL6_MASK) == 16'h0000 && (s_q.c7 & ~CTRL7_MASK) == 16'h0000)
		else $error("unused bits stored");
	chk_wr_mask: assert property (wr7 |=> s_q.c7 == ($past(req.wdata) & CTRL7_MASK))
		else $error("bank seven write wrong");
	chk_rd_idle: assert property (!req.rd |=> rdata == 16'h0000)
		else $error("read data not idle");

	// ----------------------------------------------------------------
	// shared pin
	// ----------------------------------------------------------------
	chk_pin_cmp: assert property (pin_select_cmp |-> shared_pin == comparator_output)
		else $error("pin not comparator");
	chk_pin_pg: assert property (!pin_select_cmp |-> shared_pin == reverse_power_good)
		else $error("pin not power good");

	cov_gate: cover property (battery_switch_gate_off);
	cov_clear: cover property (wr6 && req.wdata[C6_LCH_CLR] && s_q.latch);
	cov_step: cover property (s_q.c6[C6_SLEW_EN] && s_q.ref_now != $past(s_q.ref_now));
	cov_latch_rd: cover property (req.rd && req.addr == CTRL6_ADDR && s_q.latch && !s_q.c6[C6_LCH_DIS]);
	cov_strap_off: cover property (s_q.strap_done && s_q.c6[2:0] == UV_CODE_OFF);

endmodule
`default_nettype wire

// [test/reg_host.sv]
`timescale 1ns/1ns
`default_nettype none
module reg_host
	import charger_ctrl_pkg::*;
(
	input  wire logic        sys_clk, // bench clock
	input  wire logic [15:0] rdata,   // read data from the bank
	output var  reg_req_s    req      // strobed access
);
	logic [15:0] last; // answer of the latest read
	initial req = '0;
	// one-cycle strobe; the answer stands for one cycle only, so take it now
	task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(negedge sys_clk);
		req <= '{wr: w, rd: !w, addr: a, wdata: d};
		@(negedge sys_clk);
		req <= '0;
		last = rdata;
	endtask
endmodule
`default_nettype wire

// [test/charger_protection_control_regs_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin errors++; $display("CHECK FAILED %0t got %h exp %h", $time, g, e); end end
module charger_protection_control_regs_tb import charger_ctrl_pkg::*; ;
	logic        sys_clk = 1'b0;
	logic        resetn = 1'b0;
	logic        ov = 1'b0, raw = 1'b0, psel = 1'b0, rpg = 1'b0, b3 = 1'b0;
	logic        strap = 1'b0, fb = 1'b0;
	logic [11:0] target = 12'h000;
	logic [11:0] ref_out;
	logic [15:0] rdata;
	logic [16:0] idle_us;
	logic [2:0]  uv_code;
	logic        gate_off, ruv, cmp_out, pin, uv_en, abs_en;
	reg_req_s    req;
	int          errors = 0, total_checks = 0, cycles = 0;
	logic [16:0] idle_tab [4] = '{17'd40000, 17'd5000, 17'd80000, 17'd1000};

	always #5 sys_clk = ~sys_clk;

	reg_host host_u (.sys_clk(sys_clk), .rdata(rdata), .req(req));
	charger_protection_control_regs dut_u (.sys_clk(sys_clk), .resetn(resetn), .req(req), .rdata(rdata),
		.strap_high(strap), .first_battery(fb), .system_rail_overvoltage(ov),
		.battery_switch_gate_off(gate_off), .ref_target(target), .ref_out(ref_out),
		.reverse_uv_enable(ruv), .comparator_raw(raw), .comparator_output(cmp_out),
		.pin_select_cmp(psel), .reverse_power_good(rpg), .shared_pin(pin),
		.uv_threshold_code(uv_code), .uv_detect_enable(uv_en), .bank_three_bit8(b3),
		.idle_exit_us(idle_us), .abs_ov_enable(abs_en));

	task automatic finish_test();
		$display("checks %0d mismatches %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	// cut a hang short well past the longest slew wait
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 20000) begin
			errors++;
			finish_test();
		end
	end

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		host_u.acc(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a);
		host_u.acc(1'b0, a, 16'h0000);
	endtask

	task automatic t_reset();
		rd(CTRL6_ADDR); `CHK(host_u.last, 16'h0043)
		rd(CTRL7_ADDR); `CHK(host_u.last, 16'h0000)
		`CHK(abs_en, 1'b1)
		`CHK(ruv, 1'b1)
		`CHK(idle_us, 17'd40000)
		$display("reset values done");
	endtask

	// a step every 1600 cycles: two steps cannot be done by 1500
	task automatic t_slew();
		target = 12'h002;
		repeat (1500) @(negedge sys_clk);
		`CHK(ref_out < 12'h002, 1'b1)
		for (int i = 0; i < 6000 && ref_out !== 12'h002; i++) @(negedge sys_clk);
		`CHK(ref_out, 12'h002)
		wr(CTRL6_ADDR, 16'h0003);
		target = 12'h0ff;
		repeat (4) @(negedge sys_clk);
		`CHK(ref_out, 12'h0ff)
		$display("slew done");
	endtask

	task automatic t_bits();
		wr(CTRL6_ADDR, 16'hffff);
		rd(CTRL6_ADDR); `CHK(host_u.last, 16'h00ef)
		ov = 1'b1;
		@(negedge sys_clk);
		`CHK(gate_off, 1'b1)
		`CHK(ruv, 1'b0)
		wr(CTRL6_ADDR, 16'h0008);
		`CHK(gate_off, 1'b0)
		wr(CTRL7_ADDR, 16'hffff);
		rd(CTRL7_ADDR); `CHK(host_u.last, 16'h0083)
		`CHK(abs_en, 1'b0)
		rd(8'h40); `CHK(host_u.last, 16'h0000)
		for (int i = 0; i < 8; i++) begin
			wr(CTRL6_ADDR, 16'h0008 | i[15:0]);
			`CHK(uv_code, i[2:0])
			`CHK(uv_en, i != 0)
		end
		for (int i = 0; i < 4; i++) begin
			b3 = i[1];
			wr(CTRL7_ADDR, {8'h00, i[0], 7'h00});
			`CHK(idle_us, idle_tab[i])
		end
		$display("fields done");
	endtask

	task automatic t_latch();
		wr(CTRL6_ADDR, 16'h0000);
		raw = 1'b1;
		@(negedge sys_clk);
		raw = 1'b0;
		@(negedge sys_clk);
		`CHK(cmp_out, 1'b1)
		rd(CTRL6_ADDR); `CHK(host_u.last, 16'h0010)
		wr(CTRL6_ADDR, 16'h0010);
		`CHK(cmp_out, 1'b0)
		rd(CTRL6_ADDR); `CHK(host_u.last, 16'h0000)
		wr(CTRL6_ADDR, 16'h0008);
		raw = 1'b1;
		psel = 1'b1;
		@(negedge sys_clk);
		`CHK(pin, 1'b1)
		raw = 1'b0;
		rpg = 1'b1;
		@(negedge sys_clk);
		`CHK(cmp_out, 1'b0)
		`CHK(pin, 1'b0)
		psel = 1'b0;
		@(negedge sys_clk);
		`CHK(pin, 1'b1)
		$display("latch and pin done");
	endtask

	// a reset in mid-run with the strap high, then with a first battery
	task automatic t_strap();
		for (int i = 0; i < 2; i++) begin
			strap = (i == 0);
			fb = (i == 1);
			resetn = 1'b0;
			repeat (5) @(negedge sys_clk);
			resetn = 1'b1;
			repeat (2) @(negedge sys_clk);
			rd(CTRL6_ADDR); `CHK(host_u.last, 16'h0040)
		end
		$display("strap done");
	endtask

	initial begin
		repeat (5) @(negedge sys_clk);
		resetn = 1'b1;
		repeat (2) @(negedge sys_clk);
		t_reset();
		t_slew();
		t_bits();
		t_latch();
		t_strap();
		finish_test();
	end
endmodule
`default_nettype wire
